/* hdl/stp_map.svh */
// constants for the speech test serial port: timing counts, offsets, fields and reset values
`ifndef STP_MAP_SVH
`define STP_MAP_SVH
`define STP_CORE_HZ      250000000
`define STP_BIT_HZ       104000
`define STP_SAMPLE_HZ    8000
`define STP_WORD_BITS    13
`define STP_HALF_CYC     (`STP_CORE_HZ / (2 * `STP_BIT_HZ))
`define STP_FIFO_DEPTH   16
`define STP_REG_CTRL     12'h000
`define STP_REG_STATUS   12'h004
`define STP_REG_COUNT    12'h008
`define STP_CTRL_ENABLE  0
`define STP_CTRL_USEMSG  1
`define STP_CTRL_MODE_LO 2
`define STP_CTRL_MODE_HI 3
`define STP_CTRL_RESET   4'h0
`endif

/* hdl/stp_pkg.sv */
// types shared by the speech test serial port
package stp_pkg;
  // mode as {line1, line2}
  typedef enum logic [1:0] {
    STP_MODE_NORMAL = 2'b00,
    STP_MODE_DOWN   = 2'b01,
    STP_MODE_UP     = 2'b10,
    STP_MODE_ACOUS  = 2'b11
  } stp_mode_t;
  // link sequencer states, one-hot
  typedef enum logic [4:0] {
    STP_ST_IDLE  = 5'b00001,
    STP_ST_ARMED = 5'b00010,
    STP_ST_GAP   = 5'b00100,
    STP_ST_LOW   = 5'b01000,
    STP_ST_HIGH  = 5'b10000
  } stp_state_t;
endpackage

/* hdl/stp_port.sv */
// speech test serial port: sample fifo and the handset end of the link
//
// The APB slave port and the placing of the registers were decided locally.
`include "stp_map.svh"

module stp_fifo #(
  parameter int WIDTH = `STP_WORD_BITS,
  parameter int DEPTH = `STP_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  if ((DEPTH < 2) || ((1 << AW) != DEPTH)) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             inReady_ff;
  logic             outValid_ff;
  wire              push     = inValid & inReady_ff;
  wire              pop      = outValid_ff & outReady;
  wire  [AW:0]      nxtCount = count_ff + (AW+1)'(push) - (AW+1)'(pop);

  assign inReady  = inReady_ff;
  assign outValid = outValid_ff;
  assign outData  = mem[rdPtr_ff];

  // storage has no reset; only the pointers, count and flags need one
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // flags are registered so the filling side sees an honest, glitch-free ready
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      inReady_ff  <= 1'b1;
      outValid_ff <= 1'b0;
    end else begin
      wrPtr_ff    <= wrPtr_ff + AW'(push);
      rdPtr_ff    <= rdPtr_ff + AW'(pop);
      count_ff    <= nxtCount;
      inReady_ff  <= (nxtCount != (AW+1)'(DEPTH));
      outValid_ff <= (nxtCount != '0);
    end
  end
endmodule

module stp_port #(
  parameter int HALF_CYC   = `STP_HALF_CYC,
  parameter int FIFO_DEPTH = `STP_FIFO_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             linkClkOut,
  output logic             linkDataOut,
  input  wire logic        linkDataIn,
  input  wire logic        testCtl1,
  input  wire logic        testCtl2,
  input  wire logic        simRst_b,
  input  wire logic        frameSync,
  input  wire logic [12:0] decData,
  input  wire logic        decValid,
  output logic             decReady,
  output logic      [12:0] encData,
  output logic             encValid,
  input  wire logic        encReady,
  output logic             xcodeRst_b,
  output logic             convRst_b,
  output logic             xcodeRestart
);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int HALF_I = HALF_CYC;
  if (HALF_CYC < 2) begin : g_bad_half
    $error("half bit period must be at least two core cycles");
  end
  if (`STP_WORD_BITS * `STP_SAMPLE_HZ != `STP_BIT_HZ) begin : g_bad_rate
    $error("bit rate must carry 13-bit words at the sample rate");
  end

  // two-flop synchronisers for every pin from the simulator
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 4'h1;
      sync2_ff <= 4'h1;
    end else begin
      sync1_ff <= {linkDataIn, testCtl1, testCtl2, simRst_b};
      sync2_ff <= sync1_ff;
    end
  end
  wire dataInS = sync2_ff[3];
  wire ctl1S   = sync2_ff[2];
  wire ctl2S   = sync2_ff[1];
  wire simRstS = sync2_ff[0];

  // apb slave: one wait state, answer registered
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [3:0]  ctrl_ff;
  logic [15:0] rxWords_ff;
  logic [15:0] txWords_ff;
  logic [1:0]  testMode_ff;
  logic        running;
  wire         apbAccess = psel & penable;
  wire         apbDone   = apbAccess & pready_ff;
  wire         hitCtrl   = (paddr == `STP_REG_CTRL);
  wire         hitStatus = (paddr == `STP_REG_STATUS);
  wire         hitCount  = (paddr == `STP_REG_COUNT);
  wire         hitAny    = hitCtrl | hitStatus | hitCount;
  wire  [31:0] rdMux     = hitCtrl   ? {28'h0000000, ctrl_ff} :
                           hitStatus ? {28'h0000000, running, simRstS, testMode_ff} :
                           hitCount  ? {txWords_ff, rxWords_ff} : 32'h00000000;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apbAccess & ~pready_ff;
      prdata_ff  <= (apbAccess & ~pready_ff & ~pwrite) ? rdMux : 32'h00000000;
      pslverr_ff <= apbAccess & ~pready_ff & ~hitAny;
    end
  end

  // control register: write lands on the edge that completes the access
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `STP_CTRL_RESET;
    end else if (apbDone & pwrite & hitCtrl) begin
      ctrl_ff <= pwdata[3:0];
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // mode source: the pins, or the mode that the over-the-air command put in ctrl
  wire        enable  = ctrl_ff[`STP_CTRL_ENABLE];
  wire  [1:0] msgMode = ctrl_ff[`STP_CTRL_MODE_HI:`STP_CTRL_MODE_LO];
  wire  [1:0] effMode = ctrl_ff[`STP_CTRL_USEMSG] ? msgMode : {ctl1S, ctl2S};

  // reset handling: converters and transcoder held while the pin is low,
  // mode latched at the release, and transcoders restarted there unless the latched mode is normal
  logic simRstPrev_ff;
  logic xcodeRst_b_ff;
  logic convRst_b_ff;
  logic xcodeRestart_ff;
  wire  rstRelease = simRstS & ~simRstPrev_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      simRstPrev_ff   <= 1'b1;
      xcodeRst_b_ff   <= 1'b0;
      convRst_b_ff    <= 1'b0;
      xcodeRestart_ff <= 1'b0;
      testMode_ff     <= stp_pkg::STP_MODE_NORMAL;
    end else begin
      simRstPrev_ff   <= simRstS;
      xcodeRst_b_ff   <= simRstS;
      convRst_b_ff    <= simRstS;
      xcodeRestart_ff <= rstRelease & (effMode != stp_pkg::STP_MODE_NORMAL);
      if (rstRelease) begin
        testMode_ff <= effMode;
      end
    end
  end
  assign xcodeRst_b   = xcodeRst_b_ff;
  assign convRst_b    = convRst_b_ff;
  assign xcodeRestart = xcodeRestart_ff;

  // decoded samples wait here; a slow link stalls the decoder through decReady
  logic [12:0] fifoData;
  logic        fifoValid;
  logic        fifoPop;
  stp_fifo #(
    .WIDTH (`STP_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_txFifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inData   (decData),
    .inValid  (decValid),
    .inReady  (decReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // link sequencer
  stp_pkg::stp_state_t state_ff;
  stp_pkg::stp_state_t nxtState;
  logic [HW-1:0]       halfCnt_ff;
  logic [3:0]          bitCnt_ff;
  logic [12:0]         txShift_ff;
  logic [12:0]         rxShift_ff;
  logic                curTx_ff;
  logic                curRx_ff;
  logic                linkClk_ff;
  logic                linkData_ff;
  logic [12:0]         encData_ff;
  logic                encValid_ff;
  wire needTx    = (testMode_ff == stp_pkg::STP_MODE_DOWN) |
                   (testMode_ff == stp_pkg::STP_MODE_ACOUS);
  wire needRx    = (testMode_ff == stp_pkg::STP_MODE_UP) |
                   (testMode_ff == stp_pkg::STP_MODE_ACOUS);
  wire halfDone  = (halfCnt_ff == HW'(HALF_CYC - 1));
  wire lastBit   = (bitCnt_ff == 4'(`STP_WORD_BITS - 1));
  wire live      = simRstS & enable & (testMode_ff != stp_pkg::STP_MODE_NORMAL);
  // a word starts only when every active direction can move a whole sample
  wire startWord = (state_ff == stp_pkg::STP_ST_GAP) & live &
                   (~needTx | fifoValid) & (~needRx | ~encValid_ff);
  wire wordEnd   = (state_ff == stp_pkg::STP_ST_HIGH) & halfDone & lastBit;
  wire enterLow  = (nxtState == stp_pkg::STP_ST_LOW) & (state_ff != stp_pkg::STP_ST_LOW);
  wire enterHigh = (nxtState == stp_pkg::STP_ST_HIGH) & (state_ff != stp_pkg::STP_ST_HIGH);
  assign fifoPop = startWord & needTx;
  assign running = (state_ff == stp_pkg::STP_ST_LOW) | (state_ff == stp_pkg::STP_ST_HIGH);

  // next state; losing the simulator reset or enable aborts any word at once
  always_comb begin
    nxtState = state_ff;
    case (state_ff)
      stp_pkg::STP_ST_IDLE: begin
        if (live) begin
          nxtState = stp_pkg::STP_ST_ARMED;
        end
      end
      stp_pkg::STP_ST_ARMED: begin
        if (frameSync) begin
          nxtState = stp_pkg::STP_ST_GAP;
        end
      end
      stp_pkg::STP_ST_GAP: begin
        if (startWord) begin
          nxtState = stp_pkg::STP_ST_LOW;
        end
      end
      stp_pkg::STP_ST_LOW: begin
        if (halfDone) begin
          nxtState = stp_pkg::STP_ST_HIGH;
        end
      end
      stp_pkg::STP_ST_HIGH: begin
        if (halfDone) begin
          nxtState = lastBit ? stp_pkg::STP_ST_GAP : stp_pkg::STP_ST_LOW;
        end
      end
      default: begin
        nxtState = stp_pkg::STP_ST_IDLE;
      end
    endcase
    if (!live) begin
      nxtState = stp_pkg::STP_ST_IDLE;
    end
  end

  // state, half-period timer and bit counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= stp_pkg::STP_ST_IDLE;
      halfCnt_ff <= '0;
      bitCnt_ff  <= 4'h0;
    end else begin
      state_ff   <= nxtState;
      halfCnt_ff <= (enterLow | enterHigh | ~running) ? '0 : halfCnt_ff + HW'(1);
      if (startWord) begin
        bitCnt_ff <= 4'h0;
      end else if ((state_ff == stp_pkg::STP_ST_HIGH) & halfDone & ~lastBit) begin
        bitCnt_ff <= bitCnt_ff + 4'h1;
      end
    end
  end

  // pins: clock low only in the low half, data moves only on the falling edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      linkClk_ff  <= 1'b1;
      linkData_ff <= 1'b0;
      txShift_ff  <= 13'h0000;
      curTx_ff    <= 1'b0;
      curRx_ff    <= 1'b0;
    end else begin
      linkClk_ff <= (nxtState != stp_pkg::STP_ST_LOW);
      if (startWord) begin
        txShift_ff  <= {fifoData[11:0], 1'b0};
        linkData_ff <= needTx & fifoData[12];
        curTx_ff    <= needTx;
        curRx_ff    <= needRx;
      end else if (enterLow) begin
        txShift_ff  <= {txShift_ff[11:0], 1'b0};
        linkData_ff <= curTx_ff & txShift_ff[12];
      end
    end
  end

  // receive: take the synchronised data bit as the clock rises
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxShift_ff <= 13'h0000;
    end else if (enterHigh) begin
      rxShift_ff <= {rxShift_ff[11:0], dataInS};
    end
  end

  // finished sample toward the encoder; a new receiving word never starts while one waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      encData_ff  <= 13'h0000;
      encValid_ff <= 1'b0;
      rxWords_ff  <= 16'h0000;
      txWords_ff  <= 16'h0000;
    end else begin
      if (wordEnd & curRx_ff) begin
        encData_ff  <= rxShift_ff;
        encValid_ff <= 1'b1;
      end else if (encReady) begin
        encValid_ff <= 1'b0;
      end
      rxWords_ff <= rxWords_ff + 16'(wordEnd & curRx_ff);
      txWords_ff <= txWords_ff + 16'(wordEnd & curTx_ff);
    end
  end
  assign linkClkOut  = linkClk_ff;
  assign linkDataOut = linkData_ff;
  assign encData     = encData_ff;
  assign encValid    = encValid_ff;

  // helper counters read only by the checks below
  logic [15:0] lowLen_ff;
  logic [3:0]  falls_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowLen_ff <= 16'h0000;
      falls_ff  <= 4'h0;
    end else begin
      lowLen_ff <= linkClk_ff ? 16'h0000 : lowLen_ff + 16'h0001;
      if (startWord) begin
        falls_ff <= 4'h0;
      end else if (enterLow) begin
        falls_ff <= falls_ff + 4'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_clk_rest_high: assert property (
    (state_ff != stp_pkg::STP_ST_LOW) |-> linkClkOut)
    else $error("bit clock low outside a low half period");
  a_half_period: assert property (
    $rose(linkClkOut) && !$past(running, 2) == 1'b0 |-> $past(lowLen_ff) == 16'(HALF_I - 1))
    else $error("bit clock low half has the wrong length");
  a_word_length: assert property (
    wordEnd |-> falls_ff == 4'(`STP_WORD_BITS - 1) && lastBit)
    else $error("word did not take thirteen clocked bits");
  a_msb_first: assert property (
    startWord && needTx |=> linkDataOut == $past(fifoData[12]) && !linkClkOut)
    else $error("first bit out is not the sample msb");
  a_data_on_fall: assert property (
    !$fell(linkClkOut) |-> $stable(linkDataOut))
    else $error("output data moved away from a falling edge");
  a_rx_on_rise: assert property (
    $rose(linkClkOut) && running |-> rxShift_ff[0] == $past(dataInS))
    else $error("receive bit not taken at the rising edge");
  a_restart_pulse: assert property (
    $rose(simRstS) && effMode != stp_pkg::STP_MODE_NORMAL |=> xcodeRestart ##1 !xcodeRestart)
    else $error("transcoder restart missing after reset release");
  a_conv_held: assert property (
    !simRstS |=> !convRst_b && !xcodeRst_b)
    else $error("converters not held while simulator reset is low");
  a_wait_frame: assert property (
    state_ff == stp_pkg::STP_ST_ARMED && !frameSync |=> linkClkOut && !running)
    else $error("clocking started before the block boundary");
endmodule

/* tb/stp_sim_model.sv */
// behavioural test simulator at the far end of the speech link
module stp_sim_model (
  input  wire logic linkClk,
  input  wire logic rxLine,
  input  wire logic simRst_b,
  output logic      txLine
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [12:0] txQ[$];
  logic [12:0] rxQ[$];
  logic [12:0] txWord;
  logic [12:0] rxWord;
  int          bitIdx;
  time         lastFall;
  time         period;
  initial begin
    txLine = 1'b0;
    bitIdx = 0;
    lastFall = 0;
    period = 0;
    txWord = '0;
    rxWord = '0;
  end
  // a half-sent word is dropped when the reset line is released; a rising edge of a
  // word that the handset cuts off while reset is low must not misalign the count
  always @(posedge simRst_b) bitIdx = 0;
  // launch on the falling edge, msb first; an empty queue sends zeros
  always @(negedge linkClk) begin
    period = $time - lastFall;
    lastFall = $time;
    if (bitIdx == 0) txWord = (txQ.size() > 0) ? txQ.pop_front() : 13'h0000;
    txLine <= txWord[12 - bitIdx];
  end
  // capture on the rising edge; thirteen bits close a word
  always @(posedge linkClk) begin
    rxWord = {rxWord[11:0], rxLine};
    bitIdx = bitIdx + 1;
    if (bitIdx == 13) begin
      rxQ.push_back(rxWord);
      bitIdx = 0;
      // line is meaningless between words, so it never holds the last bit
      txLine <= #12 ~txLine;
    end
  end
endmodule

/* tb/stp_port_bench.sv */
// self-checking bench for the speech test serial port
`include "stp_map.svh"
module stp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic        linkClkOut, linkDataOut, linkDataIn, testCtl1, testCtl2, simRst_b, e;
  logic        frameSync, decValid, decReady, encValid, encReady;
  logic        xcodeRst_b, convRst_b, xcodeRestart;
  logic [12:0] decData, encData;
  int          err_count, check_count;
  // half period of 8 core cycles gives the 64 ns bench link clock
  stp_port #(.HALF_CYC(8), .FIFO_DEPTH(16)) u_stp_port (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linkClkOut(linkClkOut), .linkDataOut(linkDataOut), .linkDataIn(linkDataIn),
    .testCtl1(testCtl1), .testCtl2(testCtl2), .simRst_b(simRst_b), .frameSync(frameSync),
    .decData(decData), .decValid(decValid), .decReady(decReady), .encData(encData),
    .encValid(encValid), .encReady(encReady), .xcodeRst_b(xcodeRst_b),
    .convRst_b(convRst_b), .xcodeRestart(xcodeRestart));
  stp_sim_model u_stp_sim_model (
    .linkClk(linkClkOut), .rxLine(linkDataOut), .simRst_b(simRst_b), .txLine(linkDataIn));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one apb transfer; waits on pready, never a fixed count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wdat);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wdat;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    chk("apb answer", 32'(n < 50), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [12:0] wd(input int i);
    return 13'(i * 13'h0259 + 13'h1000);
  endfunction
  // sets the mode pins, waits, pulses the simulator reset and watches the restart
  task simReset(input logic [1:0] pins, input logic [1:0] mode);
    int p;
    testCtl1 <= pins[1];
    testCtl2 <= pins[0];
    tick(20);
    simRst_b <= 1'b0;
    tick(10);
    chk("xcode reset", xcodeRst_b, 32'h0);
    chk("conv reset", convRst_b, 32'h0);
    u_stp_sim_model.rxQ.delete();
    u_stp_sim_model.txQ.delete();
    simRst_b <= 1'b1;
    p = 0;
    repeat (20) begin
      @(posedge core_clk);
      if (xcodeRestart === 1'b1) p++;
    end
    chk("restart pulses", 32'(p), 32'(mode != 2'b00));
    chk("xcode released", xcodeRst_b, 32'h1);
    chk("clock waits frame", linkClkOut, 32'h1);
    apb(1'b0, `STP_REG_STATUS, 32'h0);
    chk("status", d, {28'h0, 2'b01, mode});
  endtask
  task fill(input int cnt, input int base);
    int n;
    decValid <= 1'b1;
    for (int i = 0; i < cnt; i++) begin
      decData <= wd(base + i);
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (decReady !== 1'b1 && n < 50);
      chk("dec ready", 32'(n < 50), 32'h1);
    end
    decValid <= 1'b0;
  endtask
  task frame;
    frameSync <= 1'b1;
    @(posedge core_clk);
    frameSync <= 1'b0;
  endtask
  task waitRx(input int cnt);
    int n;
    n = 0;
    while (u_stp_sim_model.rxQ.size() < cnt && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk("words seen", 32'(u_stp_sim_model.rxQ.size()), 32'(cnt));
  endtask
  // stalls the encoder side, then takes one received word
  task takeEnc(input logic [12:0] exp, input int stall);
    int n;
    n = 0;
    // let the clear of the previous word land before looking for the next one
    @(posedge core_clk);
    while (encValid !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk("enc valid", 32'(n < 2000), 32'h1);
    tick(stall);
    chk("uplink word", encData, exp);
    chk("clock held", linkClkOut, 32'h1);
    encReady <= 1'b1;
    @(posedge core_clk);
    encReady <= 1'b0;
  endtask
  initial begin
    #200000;
    err_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, frameSync, decValid, encReady, testCtl1, testCtl2} = '0;
    {paddr, pwdata, decData, d, e} = '0;
    simRst_b = 1'b1;
    rst_b = 1'b0;
    err_count = 0;
    check_count = 0;
    tick(4);
    rst_b <= 1'b1;
    tick(2);
    chk("idle clock", linkClkOut, 32'h1);
    apb(1'b0, `STP_REG_CTRL, 32'h0);
    chk("ctrl reset", d, 32'h0);
    apb(1'b1, `STP_REG_CTRL, 32'h1);
    apb(1'b0, `STP_REG_CTRL, 32'h0);
    chk("ctrl", d, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", d, 32'h0);
    $display("test registers done");
    // downlink by pins: buffer filled to refusal before the block starts
    simReset(2'b01, 2'b01);
    fill(16, 0);
    tick(2);
    chk("fifo full", decReady, 32'h0);
    frame();
    waitRx(16);
    for (int i = 0; i < 16; i++) chk("down word", u_stp_sim_model.rxQ[i], wd(i));
    chk("bit period", 32'(u_stp_sim_model.period), 32'd64);
    tick(20);
    chk("clock rests", linkClkOut, 32'h1);
    chk("fifo drained", decReady, 32'h1);
    apb(1'b0, `STP_REG_COUNT, 32'h0);
    chk("words sent", {16'h0, d[31:16]}, 32'd16);
    $display("test downlink done");
    // uplink by pins, receiver stalled on the first word
    simReset(2'b10, 2'b10);
    for (int i = 0; i < 3; i++) u_stp_sim_model.txQ.push_back(wd(i + 5));
    frame();
    for (int i = 0; i < 3; i++) takeEnc(wd(i + 5), (i == 0) ? 100 : 0);
    $display("test uplink done");
    // acoustic through the command path while pins say normal
    apb(1'b1, `STP_REG_CTRL, 32'hf);
    simReset(2'b00, 2'b11);
    u_stp_sim_model.txQ.push_back(wd(10));
    fill(1, 9);
    frame();
    takeEnc(wd(10), 0);
    waitRx(1);
    chk("acoustic down", u_stp_sim_model.rxQ[0], wd(9));
    $display("test acoustic done");
    // normal mode never clocks the link
    apb(1'b1, `STP_REG_CTRL, 32'h1);
    simReset(2'b00, 2'b00);
    fill(1, 3);
    frame();
    tick(200);
    chk("normal idle", linkClkOut, 32'h1);
    chk("normal none", 32'(u_stp_sim_model.rxQ.size()), 32'h0);
    $display("test normal done");
    stop_test();
  end
endmodule
